/* common/reading_filter_regs.vh */
`ifndef READING_FILTER_REGS_VH
`define READING_FILTER_REGS_VH

// Data widths
`define RDG_W            16
`define SUM_W            24
`define CNT_CODE_W       3
`define WIN_DEPTH        128
`define WIN_IDX_W        7
`define FILL_W           8

// Configuration groups, stepped by the advance key
`define GRP_FILTER       2'h0
`define GRP_COUNT        2'h1
`define GRP_LIMIT        2'h2
`define GRP_ALARM        2'h3

// Items inside the filter setup group
`define FIL_ITEM_TYPE    3'h0
`define FIL_ITEM_DISP    3'h1
`define FIL_ITEM_AOUT    3'h2

// Items inside the limit and alarm groups (bit index of the group byte)
`define ITEM_ZONE1       3'h0
`define ITEM_INV1        3'h1
`define ITEM_FILT1       3'h2
`define ITEM_ZONE2       3'h3
`define ITEM_INV2        3'h4
`define ITEM_FILT2       3'h5
`define ITEM_DISABLE     3'h6
`define ITEM_AUX         3'h7

// Selector encodings
`define FTYPE_ADAPTIVE   1'h0
`define FTYPE_FIXED      1'h1
`define SRC_RAW          2'h0
`define SRC_FILT         2'h1
`define SRC_PEAK         2'h2
`define SRC_VALLEY       2'h3

// Reset values
`define RST_FTYPE        1'h0
`define RST_DISP_SRC     1'h1
`define RST_AOUT_SRC     2'h1
`define RST_CNT_CODE     3'h6
`define RST_GROUP_BITS   8'h24

// Adaptive filter: a deviation beyond this step, in one direction,
// for this many readings in a row counts as a systematic change
`define ADAPT_STEP       17'h00040
`define ADAPT_RUN        3'h3

`endif

/* core/limit_comparator.v */
`timescale 1ns/10ps
`default_nettype none

module limit_comparator
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [15:0] raw_reading,
  input  wire [15:0] filt_reading,
  input  wire [15:0] limit_value,
  input  wire        zone_below,
  input  wire        output_invert,
  input  wire        use_filtered,
  input  wire        enable,
  output reg         active,
  output reg         drive
);

  wire signed [15:0] pick;
  wire               next_active;

  assign pick = use_filtered ? filt_reading : raw_reading; // RULE9 RULE14
  assign next_active = enable &&
                       (zone_below ? (pick < $signed(limit_value))
                                   : (pick > $signed(limit_value))); // RULE19 RULE7 RULE12

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      active <= 1'b0;
      drive  <= 1'b0;
    end
    else
    begin
      active <= next_active;
      // Inverted outputs rest on and switch off while active
      drive  <= next_active ^ output_invert; // RULE8 RULE13
    end
  end

endmodule // limit_comparator

`default_nettype wire

/* core/reading_filter_setpoint_compare.v */
// Function
// RULE1: Filter type: adaptive default, fixed average
// RULE2: Adaptive: drop averaging on systematic change
// RULE3: Sample count 1..128 powers of two, 64
// RULE4: Fixed uses count; adaptive uses it as limit
// RULE5: Display source raw or filtered, filtered default
// RULE6: Analog source raw, filtered, peak, valley
// RULE7: Setpoint zone bit: above or below
// RULE8: Setpoint output polarity bit per setpoint
// RULE9: Setpoint compares raw or filtered reading
// RULE10: Shared bit disables both setpoints' action
// RULE11: Shared bit darkens both setpoint lamps
// RULE12: Alarms act as setpoints with zone bits
// RULE13: Alarm output polarity bit per alarm
// RULE14: Alarm compares raw or filtered reading
// RULE15: Shared bit disables alarms and their lamps
// RULE16: External alarm clear honoured only when enabled
// RULE17: Group selections pending until advance commits
// RULE18: Fixed mean over sliding window, partial while filling
// RULE19: Comparators: above/below strict, disabled inactive
// RULE20: Peak and valley track since reset
`timescale 1ns/10ps
`default_nettype none
`include "reading_filter_regs.vh"

module reading_filter_setpoint_compare
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        reading_valid,
  input  wire [15:0] reading,
  input  wire [15:0] limit1_value,
  input  wire [15:0] limit2_value,
  input  wire [15:0] alarm1_value,
  input  wire [15:0] alarm2_value,
  input  wire        external_alarm_clear,
  input  wire        menu_item_write,
  input  wire [2:0]  menu_item_sel,
  input  wire [2:0]  menu_item_value,
  input  wire        menu_advance,
  output reg  [1:0]  menu_group,
  output reg  [15:0] filtered_reading,
  output reg         filtered_valid,
  output reg  [15:0] display_reading,
  output reg  [15:0] analog_out_reading,
  output reg  [15:0] peak_reading,
  output reg  [15:0] valley_reading,
  output reg  [7:0]  filter_depth,
  output wire        limit1_out,
  output wire        limit2_out,
  output wire        alarm1_out,
  output wire        alarm2_out,
  output reg         limit1_lamp,
  output reg         limit2_lamp,
  output reg         alarm1_lamp,
  output reg         alarm2_lamp,
  output reg         alarm_clear_honoured
);

  // Committed configuration
  reg                     filter_type_select;
  reg                     display_source_select;
  reg  [1:0]              analog_out_source_select;
  reg  [`CNT_CODE_W-1:0]  filter_sample_count;
  reg  [7:0]              limit_setup_group;
  reg  [7:0]              alarm_setup_group;

  // Pending copies edited by the menu
  reg                     pend_type;
  reg                     pend_disp;
  reg  [1:0]              pend_aout;
  reg  [`CNT_CODE_W-1:0]  pend_count;
  reg  [7:0]              pend_limit;
  reg  [7:0]              pend_alarm;
  reg                     count_changed;

  // Sliding window
  reg  [15:0]             window [0:`WIN_DEPTH-1];
  reg  [`WIN_IDX_W-1:0]   wr_ptr;
  reg  [`FILL_W-1:0]      fill;
  reg  signed [`SUM_W-1:0] sum;
  reg  [15:0]             raw_q;
  reg                     stage1_valid;
  reg                     have_extreme;
  reg  [2:0]              run_len;
  reg                     run_up;

  wire [`FILL_W-1:0]      window_n;
  wire [15:0]             oldest;
  wire signed [16:0]      deviation;
  wire                    dev_up;
  wire                    dev_down;
  wire                    systematic;
  wire                    restart;
  wire signed [`SUM_W-1:0] x_ext;
  wire signed [`SUM_W-1:0] old_ext;
  wire signed [`SUM_W-1:0] mean;
  wire                    limits_enable;
  wire                    alarms_enable;
  wire                    clear_now;
  wire                    limit1_active;
  wire                    limit2_active;
  wire                    alarm1_active;
  wire                    alarm2_active;

  assign window_n  = 8'h01 << filter_sample_count; // RULE3
  assign oldest    = window[wr_ptr - window_n[`WIN_IDX_W-1:0]];
  assign x_ext     = {{(`SUM_W-16){reading[15]}}, reading};
  assign old_ext   = {{(`SUM_W-16){oldest[15]}}, oldest};
  assign deviation = $signed({reading[15], reading}) -
                     $signed({filtered_reading[15], filtered_reading});
  assign dev_up    = deviation > $signed(`ADAPT_STEP);
  assign dev_down  = deviation < -$signed(`ADAPT_STEP);
  // A single noisy sample never restarts; a run in one direction does
  assign systematic = (filter_type_select == `FTYPE_ADAPTIVE) && have_extreme &&
                      (run_len == `ADAPT_RUN - 3'h1) &&
                      ((dev_up && run_up) || (dev_down && !run_up)); // RULE2
  assign restart   = systematic || count_changed;
  assign mean      = sum / $signed({{(`SUM_W-`FILL_W){1'b0}}, fill}); // RULE18

  // Menu: edits stay pending until the advance key commits the group
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      menu_group               <= `GRP_FILTER;
      filter_type_select       <= `RST_FTYPE; // RULE1
      display_source_select    <= `RST_DISP_SRC;
      analog_out_source_select <= `RST_AOUT_SRC;
      filter_sample_count      <= `RST_CNT_CODE;
      limit_setup_group        <= `RST_GROUP_BITS;
      alarm_setup_group        <= `RST_GROUP_BITS;
      pend_type                <= `RST_FTYPE;
      pend_disp                <= `RST_DISP_SRC;
      pend_aout                <= `RST_AOUT_SRC;
      pend_count               <= `RST_CNT_CODE;
      pend_limit               <= `RST_GROUP_BITS;
      pend_alarm               <= `RST_GROUP_BITS;
      count_changed            <= 1'b0;
    end
    else
    begin
      count_changed <= 1'b0;
      if (menu_advance)
      begin
        case (menu_group)
          `GRP_FILTER:
          begin
            filter_type_select       <= pend_type;
            display_source_select    <= pend_disp;
            analog_out_source_select <= pend_aout;
          end
          `GRP_COUNT:
          begin
            filter_sample_count <= pend_count;
            // Old window contents would be averaged with a wrong depth
            count_changed       <= pend_count != filter_sample_count;
          end
          `GRP_LIMIT:
            limit_setup_group <= pend_limit;
          `GRP_ALARM:
            alarm_setup_group <= pend_alarm;
          default:
            limit_setup_group <= limit_setup_group;
        endcase
        menu_group <= menu_group + 2'h1; // RULE17
      end
      else if (menu_item_write)
      begin
        case (menu_group)
          `GRP_FILTER:
          begin
            if (menu_item_sel == `FIL_ITEM_TYPE)
              pend_type <= menu_item_value[0];
            if (menu_item_sel == `FIL_ITEM_DISP)
              pend_disp <= menu_item_value[0];
            if (menu_item_sel == `FIL_ITEM_AOUT)
              pend_aout <= menu_item_value[1:0];
          end
          `GRP_COUNT:
            pend_count <= menu_item_value;
          `GRP_LIMIT:
            pend_limit[menu_item_sel] <= menu_item_value[0];
          `GRP_ALARM:
            pend_alarm[menu_item_sel] <= menu_item_value[0];
          default:
            pend_type <= pend_type;
        endcase
      end
    end
  end

  // Window storage has no reset; fill decides which entries count
  always @(posedge clk_sys)
  begin
    if (reading_valid)
      window[wr_ptr] <= reading;
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_ptr       <= {`WIN_IDX_W{1'b0}};
      fill         <= {`FILL_W{1'b0}};
      sum          <= {`SUM_W{1'b0}};
      raw_q        <= 16'h0000;
      stage1_valid <= 1'b0;
      have_extreme <= 1'b0;
      run_len      <= 3'h0;
      run_up       <= 1'b0;
      peak_reading   <= 16'h0000;
      valley_reading <= 16'h0000;
    end
    else
    begin
      stage1_valid <= reading_valid;
      if (count_changed && !reading_valid)
      begin
        fill <= {`FILL_W{1'b0}};
        sum  <= {`SUM_W{1'b0}};
      end
      if (reading_valid)
      begin
        raw_q  <= reading;
        wr_ptr <= wr_ptr + {{(`WIN_IDX_W-1){1'b0}}, 1'b1};
        if (restart)
        begin
          // Collapse to the newest reading only, then regrow
          sum  <= x_ext; // RULE2
          fill <= 8'h01;
        end
        else if (fill >= window_n)
        begin
          sum  <= sum + x_ext - old_ext; // RULE4 RULE18
          fill <= window_n;
        end
        else
        begin
          sum  <= sum + x_ext; // RULE18
          fill <= fill + 8'h01;
        end
        if (restart || !(dev_up || dev_down))
          run_len <= 3'h0;
        else if (run_len == 3'h0 || (dev_up == run_up))
          run_len <= (run_len == 3'h7) ? run_len : run_len + 3'h1;
        else
          run_len <= 3'h1;
        if (dev_up || dev_down)
          run_up <= dev_up;
        have_extreme <= 1'b1;
        if (!have_extreme || $signed(reading) > $signed(peak_reading))
          peak_reading <= reading; // RULE20
        if (!have_extreme || $signed(reading) < $signed(valley_reading))
          valley_reading <= reading; // RULE20
      end
    end
  end

  // Second stage divides the window sum by the samples held
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      filtered_reading   <= 16'h0000;
      filtered_valid     <= 1'b0;
      filter_depth       <= 8'h00;
      display_reading    <= 16'h0000;
      analog_out_reading <= 16'h0000;
      limit1_lamp          <= 1'b0;
      limit2_lamp          <= 1'b0;
      alarm1_lamp          <= 1'b0;
      alarm2_lamp          <= 1'b0;
      alarm_clear_honoured <= 1'b0;
    end
    else
    begin
      filtered_valid <= stage1_valid && (fill != 8'h00);
      filter_depth   <= fill;
      if (stage1_valid && fill != 8'h00)
        filtered_reading <= mean[15:0]; // RULE4
      display_reading <= display_source_select ? filtered_reading : raw_q; // RULE5
      case (analog_out_source_select) // RULE6
        `SRC_RAW:    analog_out_reading <= raw_q;
        `SRC_FILT:   analog_out_reading <= filtered_reading;
        `SRC_PEAK:   analog_out_reading <= peak_reading;
        `SRC_VALLEY: analog_out_reading <= valley_reading;
        default:     analog_out_reading <= filtered_reading;
      endcase
      // Lamps trail the comparator state by one cycle
      limit1_lamp          <= limit1_active && !limit_setup_group[`ITEM_AUX]; // RULE11
      limit2_lamp          <= limit2_active && !limit_setup_group[`ITEM_AUX]; // RULE11
      alarm1_lamp          <= alarm1_active; // RULE15
      alarm2_lamp          <= alarm2_active; // RULE15
      alarm_clear_honoured <= clear_now; // RULE16
    end
  end

  assign limits_enable = !limit_setup_group[`ITEM_DISABLE]; // RULE10
  assign clear_now     = alarm_setup_group[`ITEM_AUX] && external_alarm_clear; // RULE16
  assign alarms_enable = !alarm_setup_group[`ITEM_DISABLE] && !clear_now; // RULE15

  limit_comparator u_limit1
  (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .raw_reading (raw_q),
    .filt_reading (filtered_reading), .limit_value (limit1_value),
    .zone_below (limit_setup_group[`ITEM_ZONE1]), .output_invert (limit_setup_group[`ITEM_INV1]),
    .use_filtered (limit_setup_group[`ITEM_FILT1]), .enable (limits_enable),
    .active (limit1_active), .drive (limit1_out)
  );

  limit_comparator u_limit2
  (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .raw_reading (raw_q),
    .filt_reading (filtered_reading), .limit_value (limit2_value),
    .zone_below (limit_setup_group[`ITEM_ZONE2]), .output_invert (limit_setup_group[`ITEM_INV2]),
    .use_filtered (limit_setup_group[`ITEM_FILT2]), .enable (limits_enable),
    .active (limit2_active), .drive (limit2_out)
  );

  limit_comparator u_alarm1
  (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .raw_reading (raw_q),
    .filt_reading (filtered_reading), .limit_value (alarm1_value),
    .zone_below (alarm_setup_group[`ITEM_ZONE1]), .output_invert (alarm_setup_group[`ITEM_INV1]),
    .use_filtered (alarm_setup_group[`ITEM_FILT1]), .enable (alarms_enable),
    .active (alarm1_active), .drive (alarm1_out)
  );

  limit_comparator u_alarm2
  (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .raw_reading (raw_q),
    .filt_reading (filtered_reading), .limit_value (alarm2_value),
    .zone_below (alarm_setup_group[`ITEM_ZONE2]), .output_invert (alarm_setup_group[`ITEM_INV2]),
    .use_filtered (alarm_setup_group[`ITEM_FILT2]), .enable (alarms_enable),
    .active (alarm2_active), .drive (alarm2_out)
  );

endmodule // reading_filter_setpoint_compare

`default_nettype wire

/* verification/reading_filter_setpoint_compare_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module reading_filter_asserts
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        reading_valid,
  input  wire logic [15:0] reading,
  input  wire logic        external_alarm_clear,
  input  wire logic        menu_advance,
  input  wire logic [1:0]  menu_group,
  input  wire logic [15:0] filtered_reading,
  input  wire logic        filtered_valid,
  input  wire logic [15:0] peak_reading,
  input  wire logic [15:0] valley_reading,
  input  wire logic [7:0]  filter_depth,
  input  wire logic        alarm1_lamp,
  input  wire logic        alarm2_lamp,
  input  wire logic        alarm_clear_honoured
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  fv_latency_a: assert property (reading_valid |-> ##2 filtered_valid)
    else $error("filtered result missing after a reading");
  fv_cause_a: assert property (filtered_valid |-> $past(reading_valid, 2))
    else $error("filtered result without a reading");
  mean_bounds_a: assert property (filtered_valid |->
    $signed(valley_reading) <= $signed(filtered_reading) &&
    $signed(filtered_reading) <= $signed(peak_reading))
    else $error("mean outside valley and peak");
  peak_catch_a: assert property (reading_valid |=>
    $signed(peak_reading) >= $signed($past(reading)) &&
    $signed(valley_reading) <= $signed($past(reading)))
    else $error("tracker missed a reading");
  depth_range_a: assert property (filtered_valid |-> filter_depth inside {[1:128]})
    else $error("averaging depth out of range");
  depth_grow_a: assert property (filtered_valid |->
    filter_depth <= $past(filter_depth) + 8'h01)
    else $error("window grew by more than one");
  group_step_a: assert property (menu_advance |=>
    menu_group == $past(menu_group) + 2'h1)
    else $error("advance did not step the group");
  group_hold_a: assert property (!menu_advance |=> $stable(menu_group))
    else $error("group moved without advance");
  clear_cause_a: assert property (alarm_clear_honoured |-> $past(external_alarm_clear))
    else $error("clear honoured without input");
  clear_lamps_a: assert property (alarm_clear_honoured [*3] |->
    !alarm1_lamp && !alarm2_lamp)
    else $error("alarm lamp lit during clear");

  cover property (filtered_valid && filter_depth == 8'h01);
  cover property (menu_advance && menu_group == 2'h3);
  cover property (alarm_clear_honoured);
endmodule // reading_filter_asserts
`default_nettype wire

/* verification/reading_front_end.sv */
`timescale 1ns/10ps
`default_nettype none
module reading_front_end
(
  input  wire logic        clk_sys,
  input  wire logic        send,
  input  wire logic [15:0] level,
  output var  logic        reading_valid,
  output var  logic [15:0] reading
);
  initial
  begin
    reading_valid = 1'b0;
    reading = 16'h0000;
  end
  // Bus toggles between readings so stale data never looks fresh
  always @(posedge clk_sys)
  begin
    reading_valid <= send;
    reading <= send ? level : ~reading;
  end
endmodule // reading_front_end
`default_nettype wire

/* verification/test_reading_filter_setpoint_compare.sv */
`timescale 1ns/10ps
`default_nettype none
module test_reading_filter_setpoint_compare;
  logic        clk_sys, sys_rst, send, external_alarm_clear;
  logic        menu_item_write, menu_advance;
  logic [2:0]  menu_item_sel, menu_item_value;
  logic [15:0] level;
  logic [15:0] limit1_value = 16'h0032;
  logic [15:0] limit2_value = 16'hFFEC;
  logic [15:0] alarm1_value = 16'h00C8;
  logic [15:0] alarm2_value = 16'h0000;
  wire         reading_valid, filtered_valid, alarm_clear_honoured;
  wire         limit1_out, limit2_out, alarm1_out, alarm2_out;
  wire         limit1_lamp, limit2_lamp, alarm1_lamp, alarm2_lamp;
  wire  [1:0]  menu_group;
  wire  [7:0]  filter_depth;
  wire  [15:0] reading, filtered_reading, display_reading, analog_out_reading;
  wire  [15:0] peak_reading, valley_reading;
  int          err_count, checks, n, src, mean;
  // First reading of the run is 10, so both trackers start there
  int          pk = 10;
  int          vl = 10;
  int          win[$];
  logic        disp_raw;
  // Group the menu should be in, counted from the advances issued
  logic [1:0]  exp_group = 2'h0;
  logic [7:0]  lc, ac;
  logic [7:0]  pat[4] = '{8'h24, 8'h1B, 8'hC0, 8'h80};

  reading_front_end u_src (.clk_sys, .send, .level, .reading_valid, .reading);
  reading_filter_setpoint_compare u_dut (.clk_sys, .sys_rst, .reading_valid, .reading,
    .limit1_value, .limit2_value, .alarm1_value, .alarm2_value, .external_alarm_clear,
    .menu_item_write, .menu_item_sel, .menu_item_value, .menu_advance, .menu_group,
    .filtered_reading, .filtered_valid, .display_reading, .analog_out_reading,
    .peak_reading, .valley_reading, .filter_depth, .limit1_out, .limit2_out,
    .alarm1_out, .alarm2_out, .limit1_lamp, .limit2_lamp, .alarm1_lamp, .alarm2_lamp,
    .alarm_clear_honoured);

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic put(input logic [2:0] s, input logic [2:0] v);
    @(posedge clk_sys);
    menu_item_write <= 1'b1;
    menu_item_sel <= s;
    menu_item_value <= v;
    @(posedge clk_sys);
    menu_item_write <= 1'b0;
  endtask

  task automatic step;
    @(posedge clk_sys);
    menu_advance <= 1'b1;
    @(posedge clk_sys);
    menu_advance <= 1'b0;
    exp_group = exp_group + 2'h1;
    #1;
  endtask

  task automatic go(input logic [1:0] g);
    for (int i = 0; i < 4 && exp_group != g; i++)
      step;
    check(menu_group, g);
    if (menu_group !== g)
      end_sim;
  endtask

  task automatic grp(input logic [1:0] g, input logic [7:0] b);
    go(g);
    for (int i = 0; i < 8; i++)
      put(i[2:0], {2'b00, b[i]});
    step;
  endtask

  task automatic feed(input int v[$]);
    foreach (v[i])
    begin
      @(posedge clk_sys);
      send <= 1'b1;
      level <= v[i][15:0];
      win.push_back(v[i]);
      if (win.size() > n)
        void'(win.pop_front());
      pk = v[i] > pk ? v[i] : pk;
      vl = v[i] < vl ? v[i] : vl;
    end
    @(posedge clk_sys);
    send <= 1'b0;
    // One stage in the source, then four to the lamps
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic act(logic [7:0] c, int k, int v, int raw);
    int r;
    r = c[3 * k + 2] ? mean : raw;
    return c[3 * k] ? (r < v) : (r > v);
  endfunction

  task automatic look;
    int raw, s;
    int q[4];
    logic [3:0] a;
    s = 0;
    foreach (win[i])
      s += win[i];
    mean = s / win.size();
    raw = win[$];
    q = '{raw, mean, pk, vl};
    a = {act(lc, 0, 50, raw), act(lc, 1, -20, raw), act(ac, 0, 200, raw), act(ac, 1, 0, raw)};
    a = a & {{2{!lc[6]}}, {2{!ac[6] && !(ac[7] && external_alarm_clear)}}};
    check(filtered_reading, mean[15:0]);
    check(filter_depth, 16'(win.size()));
    check(display_reading, disp_raw ? raw[15:0] : mean[15:0]);
    check(analog_out_reading, q[src][15:0]);
    check(peak_reading, pk[15:0]);
    check(valley_reading, vl[15:0]);
    check({limit1_out, limit2_out, alarm1_out, alarm2_out},
      a ^ {lc[1], lc[4], ac[1], ac[4]});
    check({limit1_lamp, limit2_lamp, alarm1_lamp, alarm2_lamp},
      a & {{2{!lc[7]}}, 2'b11});
    check(alarm_clear_honoured, ac[7] & external_alarm_clear);
  endtask

  initial
  begin
    {send, external_alarm_clear, menu_item_write, menu_advance} = 4'h0;
    {menu_item_sel, menu_item_value, level} = 22'h0;
    sys_rst = 1'b1;
    n = 64;
    src = 1;
    disp_raw = 1'b0;
    lc = 8'h24;
    ac = 8'h24;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    check(peak_reading, 16'h0000);
    feed('{10, 20});
    look;
    feed('{1000, 1000, 1000});
    win = '{1000};
    look;
    put(3'h1, 3'h0);
    put(3'h0, 3'h1);
    feed('{1010});
    look;
    step;
    disp_raw = 1'b1;
    put(3'h0, 3'h2);
    step;
    n = 4;
    win.delete();
    feed('{5, -7, -8});
    look;
    feed('{500, 500, 500});
    look;
    feed('{1, 2, 3, 4, 5, 6});
    look;
    for (int i = 0; i < 4; i++)
    begin
      go(2'h0);
      put(3'h2, i[2:0]);
      step;
      src = i;
      feed('{i * 100 - 150});
      look;
    end
    foreach (pat[i])
    begin
      grp(2'h2, pat[i]);
      lc = pat[i];
      grp(2'h3, pat[i]);
      ac = pat[i];
      for (int c = 0; c < 2; c++)
      begin
        @(posedge clk_sys);
        external_alarm_clear <= c[0];
        feed('{130 * c - 30});
        look;
      end
    end
    end_sim;
  end
endmodule // test_reading_filter_setpoint_compare

bind reading_filter_setpoint_compare reading_filter_asserts u_chk (.clk_sys, .sys_rst,
  .reading_valid, .reading, .external_alarm_clear, .menu_advance, .menu_group,
  .filtered_reading, .filtered_valid, .peak_reading, .valley_reading, .filter_depth,
  .alarm1_lamp, .alarm2_lamp, .alarm_clear_honoured);
`default_nettype wire
